/* hdl/sos_object_server.sv */
// Expedited service-data-object server with abort signalling for a node.
// Assumes the CAN controller hands over one received frame per req_valid
// pulse on ref_clk and takes rsp_frame whenever rsp_valid pulses.
// Back-to-back requests are served one per cycle. Request spacing is the
// master's duty and is not policed here. Expedited transfers only, so every
// object value fits in one four-byte word.
//
// Notes on behaviour
// R1: Failed access answered by eight-byte frame: 80h, index, sub-index, abort code.
// R2: Abort goes on the response identifier, echoing request index and sub-index.
// R3: Invalid or unknown command specifier aborts with 0504 0001h.
// R4: Access type an object does not support aborts with 0601 0000h.
// R5: Read of a write-only object aborts with 0601 0001h, no data.
// R6: Write to a read-only object aborts with 0601 0002h, value kept.
// R7: Index missing from the dictionary aborts with 0602 0000h.
// R8: Existing index with unsupported sub-index aborts with 0609 0011h.
// R9: Dictionary holds device_type_word-1029h set, 1800h-1803h, 1A00h-1A03h and 1F80h.
// R10: Device type at device_type_word sub 0, read-only, value 0002 0194h.
// R11: Single-entry read-only objects accept sub-index 0 only.
// R12: Device type reply: low half in bytes 4-5, high half in 6-7.
// R13: Read-only 8-bit error summary at error_summary sub 0, zero without errors.
// R14: Error summary bit 0 set on hardware fault.
// R15: Error summary bit 4 set on CAN bus fault.
// R16: Error history at error_history keeps at most ten 32-bit codes.
// R17: History sub 0 writable count, 1-10 read-only, others rejected.
// R18: Any write to history sub 0 clears entries and count.
// R19: Read of history sub n returns the code at position n.
// R20: Product name readable as string at 1008h sub 0.
// R21: Hardware version readable as string at 1009h sub 0.
// R22: Software version readable as string at 100Ah sub 0.
// R23: Index and data fields travel least significant byte first.
// R24: Writes 23h/27h/2Bh/2Fh confirmed by 60h; read 40h answered 43h-4Fh.
// R25: Master leaves over 20 ms between service requests.
// R26: Checks run command, index, sub-index, access; first failure reported.
// R27: Exactly one reply, normal or abort, per request addressed here.
`timescale 1ns/1ps

module sos_object_server
  import sos_pkg::*;
#(
  parameter logic [31:0] NAME_STR   = 32'h3130_4e58, // Arbitrary text, four characters
  parameter logic [31:0] HW_VER_STR = 32'h3030_3148, // Arbitrary text, four characters
  parameter logic [31:0] SW_VER_STR = 32'h3030_3153  // Arbitrary text, four characters
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [6:0] node_id_pin,
  input  wire logic       hw_fault_pin,
  input  wire logic       can_fault_pin,
  input  wire logic       hist_push,
  input  wire logic [31:0] hist_code,
  input  wire logic       req_valid,
  input  wire sos_frame_t req_frame,
  output logic            rsp_valid,
  output sos_frame_t      rsp_frame,
  output logic [7:0]      err_summary
);

  // Builds a reply frame; word goes out least significant byte first
  function automatic sos_frame_t make_frame(input logic [10:0] id, input logic [7:0] b0,
                                            input logic [15:0] idx, input logic [7:0] sub,
                                            input logic [31:0] word);
    sos_frame_t f;
    f.cob_id  = id;
    f.dlc     = SOS_FRAME_DLC;
    f.data[0] = b0;
    f.data[1] = idx[7:0];   // [R23]
    f.data[2] = idx[15:8];
    f.data[3] = sub;
    f.data[4] = word[7:0];  // [R12] [R23]
    f.data[5] = word[15:8];
    f.data[6] = word[23:16];
    f.data[7] = word[31:24];
    return f;
  endfunction

  // True for an index served elsewhere but present in the dictionary
  function automatic logic other_present(input logic [15:0] idx);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < SOS_OTHER_N; i++) begin
      hit = hit | (idx == SOS_IDX_OTHER[i]);
    end
    hit = hit | (idx >= SOS_IDX_TPAR_LO && idx <= SOS_IDX_TPAR_HI);  // [R9]
    hit = hit | (idx >= SOS_IDX_TMAP_LO && idx <= SOS_IDX_TMAP_HI);
    hit = hit | (idx == SOS_IDX_STARTUP);
    return hit;
  endfunction

  // Pin synchronisers
  logic [6:0] node_meta_reg;
  logic [6:0] node_id_reg;
  logic       hw_meta_reg;
  logic       hw_fault_reg;
  logic       can_meta_reg;
  logic       can_fault_reg;

  // Error history storage, position 1 in slot 0
  logic [31:0] hist_reg [SOS_HIST_DEPTH];
  logic [7:0]  hist_cnt_reg;
  logic [7:0]  hist_cnt_next;

  // Reply registers
  logic       rsp_valid_reg;
  sos_frame_t rsp_frame_reg;

  // Request fields
  logic [7:0]  cmd;
  logic [15:0] idx;
  logic [7:0]  sub;
  logic        addressed;
  assign cmd       = req_frame.data[0];
  assign idx       = {req_frame.data[2], req_frame.data[1]};  // [R23]
  assign sub       = req_frame.data[3];
  assign addressed = req_valid && (req_frame.cob_id == (SOS_RX_BASE | {4'h0, node_id_reg}));

  // Command classes
  logic is_read;
  logic is_write;
  logic cmd_ok;
  assign is_read  = (cmd == SOS_CMD_RD);
  assign is_write = (cmd == SOS_CMD_WR_ANY) || (cmd == SOS_CMD_WR4) || (cmd == SOS_CMD_WR3) ||
                    (cmd == SOS_CMD_WR2) || (cmd == SOS_CMD_WR1);  // [R24]
  assign cmd_ok   = is_read || is_write;

  // Index and sub-index existence
  logic is_single;
  logic is_hist;
  logic idx_ok;
  logic sub_ok;
  assign is_single = (idx == SOS_IDX_DEV_TYPE) || (idx == SOS_IDX_ERR_SUM) ||
                     (idx == SOS_IDX_NAME) || (idx == SOS_IDX_HW_VER) || (idx == SOS_IDX_SW_VER);
  assign is_hist   = (idx == SOS_IDX_ERR_HIST);
  assign idx_ok    = is_single || is_hist || other_present(idx);  // [R9]
  assign sub_ok    = is_single ? (sub == SOS_SUB_ZERO) :          // [R11]
                     is_hist   ? (sub <= SOS_HIST_LAST) : 1'b1;   // [R17]

  // Access class of the addressed entry; served-elsewhere objects have none here
  sos_acc_t acc;
  assign acc = is_single ? SOS_ACC_RO :                                        // [R10] [R13]
               is_hist   ? ((sub == SOS_SUB_ZERO) ? SOS_ACC_RW : SOS_ACC_RO) : // [R17]
               SOS_ACC_NONE;

  // Abort selection, first failing check wins
  logic [31:0] abort_code;
  assign abort_code = !cmd_ok                      ? SOS_AB_CMD    :  // [R3] [R26]
                      !idx_ok                      ? SOS_AB_NO_OBJ :  // [R7]
                      !sub_ok                      ? SOS_AB_NO_SUB :  // [R8]
                      (acc == SOS_ACC_NONE)        ? SOS_AB_UNSUP  :  // [R4]
                      (is_read  && acc == SOS_ACC_WO) ? SOS_AB_WO  :  // [R5]
                      (is_write && acc == SOS_ACC_RO) ? SOS_AB_RO  :  // [R6]
                      SOS_AB_NONE;

  // Error summary from synchronised fault levels
  logic [7:0] err_sum;
  always_comb begin
    err_sum                  = SOS_ERR_SUM_RST;  // [R13]
    err_sum[SOS_BIT_GENERIC] = hw_fault_reg;     // [R14]
    err_sum[SOS_BIT_COMM]    = can_fault_reg;    // [R15]
  end

  // History slot selected by sub-index n, valid for 1..10
  logic [3:0]  hist_sel;
  logic [31:0] hist_word;
  assign hist_sel  = sub[3:0] - 4'h1;
  assign hist_word = (sub != SOS_SUB_ZERO && sub <= SOS_HIST_LAST) ? hist_reg[hist_sel]
                                                                   : SOS_HIST_RST;

  // Read value and size code of a successful read
  logic [31:0] rd_word;
  logic [7:0]  rd_cmd;
  always_comb begin
    rd_word = SOS_DEV_TYPE_VAL;
    rd_cmd  = SOS_CMD_RD4;
    case (idx)
      SOS_IDX_DEV_TYPE: begin
        rd_word = SOS_DEV_TYPE_VAL;  // [R10] [R12]
      end
      SOS_IDX_ERR_SUM: begin
        rd_word = {24'h00_0000, err_sum};
        rd_cmd  = SOS_CMD_RD1;
      end
      SOS_IDX_ERR_HIST: begin
        if (sub == SOS_SUB_ZERO) begin
          rd_word = {24'h00_0000, hist_cnt_reg};
          rd_cmd  = SOS_CMD_RD1;
        end else begin
          rd_word = hist_word;  // [R19]
        end
      end
      SOS_IDX_NAME:   rd_word = NAME_STR;    // [R20]
      SOS_IDX_HW_VER: rd_word = HW_VER_STR;  // [R21]
      SOS_IDX_SW_VER: rd_word = SW_VER_STR;  // [R22]
      default:        rd_word = SOS_DEV_TYPE_VAL;
    endcase
  end

  // Reply identifier and failure flag of the addressed request
  logic [10:0] tx_id;
  logic        failed;
  assign tx_id  = SOS_TX_BASE | {4'h0, node_id_reg};  // [R2]
  assign failed = (abort_code != SOS_AB_NONE);

  // Candidate replies; an abort never carries read data
  sos_frame_t  abort_frame;
  sos_frame_t  read_frame;
  sos_frame_t  ack_frame;
  assign abort_frame = make_frame(tx_id, SOS_CMD_ABORT, idx, sub, abort_code);   // [R1] [R2]
  assign read_frame  = make_frame(tx_id, rd_cmd, idx, sub, rd_word);             // [R24]
  assign ack_frame   = make_frame(tx_id, SOS_CMD_WR_ACK, idx, sub, SOS_AB_NONE); // [R24]

  // One reply per addressed request: abort, read data or write confirm
  sos_frame_t  reply;
  assign reply = failed ? abort_frame : (is_read ? read_frame : ack_frame);  // [R5] [R27]

  // History clear on an accepted write to sub-index 0
  logic hist_clear;
  assign hist_clear = addressed && !failed && is_write && is_hist && (sub == SOS_SUB_ZERO);

  // Full history: a further push drops the oldest entry instead of counting
  logic hist_full;
  assign hist_full = (hist_cnt_reg >= SOS_HIST_LAST);

  // Count: a push in the clear cycle survives as the only entry
  always_comb begin
    if (hist_clear) begin
      hist_cnt_next = hist_push ? 8'h01 : 8'h00;  // [R18]
    end else if (hist_push && !hist_full) begin
      hist_cnt_next = hist_cnt_reg + 8'h01;       // [R16]
    end else begin
      hist_cnt_next = hist_cnt_reg;
    end
  end

  // Node id strap synchroniser; only the second flop feeds logic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      node_meta_reg <= SOS_NODE_RST;
      node_id_reg   <= SOS_NODE_RST;
    end else begin
      node_meta_reg <= node_id_pin;
      node_id_reg   <= node_meta_reg;
    end
  end

  // Hardware fault pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hw_meta_reg  <= 1'b0;
      hw_fault_reg <= 1'b0;
    end else begin
      hw_meta_reg  <= hw_fault_pin;
      hw_fault_reg <= hw_meta_reg;  // [R14]
    end
  end

  // CAN fault pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      can_meta_reg  <= 1'b0;
      can_fault_reg <= 1'b0;
    end else begin
      can_meta_reg  <= can_fault_pin;
      can_fault_reg <= can_meta_reg;  // [R15]
    end
  end

  // History shift: newest enters position 1, oldest drops off when full
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < SOS_HIST_DEPTH; i++) hist_reg[i] <= SOS_HIST_RST;
    end else if (hist_push) begin
      hist_reg[0] <= hist_code;  // [R16]
      for (int i = 1; i < SOS_HIST_DEPTH; i++) begin
        hist_reg[i] <= hist_clear ? SOS_HIST_RST : hist_reg[i-1];
      end
    end else if (hist_clear) begin
      for (int i = 0; i < SOS_HIST_DEPTH; i++) hist_reg[i] <= SOS_HIST_RST;  // [R18]
    end
  end

  // Entry count register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hist_cnt_reg <= 8'h00;
    end else begin
      hist_cnt_reg <= hist_cnt_next;  // [R16] [R18]
    end
  end

  // Reply registers; the frame holds until the next reply
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_frame_reg <= '0;
    end else begin
      rsp_valid_reg <= addressed;  // [R27]
      if (addressed) begin
        rsp_frame_reg <= reply;
      end
    end
  end

  assign rsp_valid   = rsp_valid_reg;
  assign rsp_frame   = rsp_frame_reg;
  assign err_summary = err_sum;

endmodule

/* hdl/sos_pkg.sv */
// Constants, frame carrier and access classes for the object server.
// Assumes a single 40 MHz ref_clk domain and a CAN controller outside that
// delivers and accepts whole eight-byte frames.
package sos_pkg;

  // Frame identifiers of the service channel
  localparam logic [10:0] SOS_RX_BASE    = 11'h600;
  localparam logic [10:0] SOS_TX_BASE    = 11'h580;
  localparam logic [3:0]  SOS_FRAME_DLC  = 4'h8;

  // Command specifier bytes
  localparam logic [7:0]  SOS_CMD_WR_ANY = 8'h22;
  localparam logic [7:0]  SOS_CMD_WR4    = 8'h23;
  localparam logic [7:0]  SOS_CMD_WR3    = 8'h27;
  localparam logic [7:0]  SOS_CMD_WR2    = 8'h2b;
  localparam logic [7:0]  SOS_CMD_WR1    = 8'h2f;
  localparam logic [7:0]  SOS_CMD_RD     = 8'h40;
  localparam logic [7:0]  SOS_CMD_WR_ACK = 8'h60;
  localparam logic [7:0]  SOS_CMD_RD4    = 8'h43;
  localparam logic [7:0]  SOS_CMD_RD1    = 8'h4f;
  localparam logic [7:0]  SOS_CMD_ABORT  = 8'h80;

  // Abort codes
  localparam logic [31:0] SOS_AB_NONE    = 32'h0000_0000;
  localparam logic [31:0] SOS_AB_CMD     = 32'h0504_0001;
  localparam logic [31:0] SOS_AB_UNSUP   = 32'h0601_0000;
  localparam logic [31:0] SOS_AB_WO      = 32'h0601_0001;
  localparam logic [31:0] SOS_AB_RO      = 32'h0601_0002;
  localparam logic [31:0] SOS_AB_NO_OBJ  = 32'h0602_0000;
  localparam logic [31:0] SOS_AB_NO_SUB  = 32'h0609_0011;

  // Objects served by this block
  localparam logic [15:0] SOS_IDX_DEV_TYPE = 16'h1000;
  localparam logic [15:0] SOS_IDX_ERR_SUM  = 16'h1001;
  localparam logic [15:0] SOS_IDX_ERR_HIST = 16'h1003;
  localparam logic [15:0] SOS_IDX_NAME     = 16'h1008;
  localparam logic [15:0] SOS_IDX_HW_VER   = 16'h1009;
  localparam logic [15:0] SOS_IDX_SW_VER   = 16'h100a;

  // Objects present in the dictionary but served elsewhere
  localparam int unsigned SOS_OTHER_N = 11;
  localparam logic [SOS_OTHER_N-1:0][15:0] SOS_IDX_OTHER = {
    16'h1002, 16'h1005, 16'h100c, 16'h100d, 16'h1010, 16'h1011,
    16'h1014, 16'h1016, 16'h1017, 16'h1018, 16'h1029};
  localparam logic [15:0] SOS_IDX_TPAR_LO  = 16'h1800;
  localparam logic [15:0] SOS_IDX_TPAR_HI  = 16'h1803;
  localparam logic [15:0] SOS_IDX_TMAP_LO  = 16'h1a00;
  localparam logic [15:0] SOS_IDX_TMAP_HI  = 16'h1a03;
  localparam logic [15:0] SOS_IDX_STARTUP  = 16'h1f80;

  // Values, sub-indices and field positions
  localparam logic [31:0] SOS_DEV_TYPE_VAL = 32'h0002_0194;
  localparam logic [7:0]  SOS_ERR_SUM_RST  = 8'h00;
  localparam logic [31:0] SOS_HIST_RST     = 32'h0000_0000;
  localparam logic [7:0]  SOS_SUB_ZERO     = 8'h00;
  localparam logic [7:0]  SOS_HIST_LAST    = 8'h0a;
  localparam int unsigned SOS_HIST_DEPTH   = 10;
  localparam int unsigned SOS_BIT_GENERIC  = 0;
  localparam int unsigned SOS_BIT_COMM     = 4;
  localparam logic [6:0]  SOS_NODE_RST     = 7'h00;

  // One CAN frame; data[0] is byte 0 on the wire
  typedef struct packed {
    logic [10:0]     cob_id;
    logic [3:0]      dlc;
    logic [7:0][7:0] data;
  } sos_frame_t;

  // Access class of an object entry
  typedef enum logic [1:0] {SOS_ACC_NONE, SOS_ACC_RO, SOS_ACC_RW, SOS_ACC_WO} sos_acc_t;

endpackage

/* test/sos_monitor.sv */
// Checker for the object server: reply timing, framing and abort codes.
// Assumes one ref_clk domain and synchronous active-high rst.
`timescale 1ns/1ps
module sos_monitor
  import sos_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [6:0]  node_id_pin,
  input wire logic        hw_fault_pin,
  input wire logic        can_fault_pin,
  input wire logic        hist_push,
  input wire logic [31:0] hist_code,
  input wire logic        req_valid,
  input wire sos_frame_t  req_frame,
  input wire logic        rsp_valid,
  input wire sos_frame_t  rsp_frame,
  input wire logic [7:0]  err_summary
);
  logic [6:0] n1_reg, n2_reg;
  logic [1:0] f1_reg, f2_reg;
  // Mirror of the two-flop pin synchronisers
  always_ff @(posedge ref_clk) begin
    n1_reg <= rst ? 7'h00 : node_id_pin;
    n2_reg <= rst ? 7'h00 : n1_reg;
    f1_reg <= rst ? 2'h0 : {can_fault_pin, hw_fault_pin};
    f2_reg <= rst ? 2'h0 : f1_reg;
  end
  // Request fields and abort code of the reply
  wire        hit    = req_valid && req_frame.cob_id == (SOS_RX_BASE | {4'h0, n2_reg});
  wire [7:0]  cmd    = req_frame.data[0];
  wire [15:0] idx    = {req_frame.data[2], req_frame.data[1]};
  wire [7:0]  sub    = req_frame.data[3];
  wire [31:0] code   = {rsp_frame.data[7], rsp_frame.data[6],
                        rsp_frame.data[5], rsp_frame.data[4]};
  wire        cmd_ok = cmd inside {8'h40, 8'h22, 8'h23, 8'h27, 8'h2b, 8'h2f};
  wire        single = idx inside {16'h1000, 16'h1001, 16'h1008, 16'h1009, 16'h100a};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_abort(logic [31:0] c);
    rsp_valid && rsp_frame.data[0] == SOS_CMD_ABORT && code == c;
  endsequence
  a_one_reply: assert property (hit |=> rsp_valid)
    else $error("no reply one cycle after request");
  a_no_stray: assert property (!hit |=> !rsp_valid)
    else $error("reply without request");
  a_reply_id: assert property (rsp_valid |-> rsp_frame.dlc == 4'h8 &&
    rsp_frame.cob_id == (SOS_TX_BASE | {4'h0, n2_reg})) else $error("reply id or length wrong");
  a_abort_echo: assert property (hit ##1 rsp_frame.data[0] == 8'h80 |->
    rsp_frame.data[3:1] == $past(req_frame.data[3:1])) else $error("abort lost index");
  a_bad_cmd: assert property (hit && !cmd_ok |=> s_abort(32'h0504_0001))
    else $error("bad command not aborted");
  a_dev_type: assert property (hit && cmd == 8'h40 && idx == 16'h1000 && sub == 0 |=>
    rsp_frame.data == {32'h0002_0194, 8'h00, 16'h1000, 8'h43}) else $error("device type reply");
  a_ro_write: assert property (hit && cmd_ok && cmd != 8'h40 && single && sub == 0
    |=> s_abort(32'h0601_0002)) else $error("read-only write not aborted");
  a_no_object: assert property (hit && cmd_ok && idx[15:12] != 4'h1
    |=> s_abort(32'h0602_0000)) else $error("absent index not aborted");
  a_bad_sub: assert property (hit && cmd_ok && single && sub != 0
    |=> s_abort(32'h0609_0011)) else $error("bad sub-index not aborted");
  a_err_bits: assert property (
    err_summary == {3'h0, f2_reg[1], 3'h0, f2_reg[0]}) else $error("error summary bits wrong");
endmodule

bind sos_object_server sos_monitor sos_monitor_i (.ref_clk, .rst, .node_id_pin, .hw_fault_pin,
  .can_fault_pin, .hist_push, .hist_code, .req_valid, .req_frame, .rsp_valid, .rsp_frame,
  .err_summary);

/* test/sos_master_model.sv */
// Service client model: sends one expedited request, collects the reply.
// Assumes the server answers within four ref_clk cycles.
`timescale 1ns/1ps
module sos_master_model
  import sos_pkg::*;
#(
  parameter int GAP_CYC = 8 // Request spacing, shortened from 20 ms to keep runs short
) (
  input  wire logic       ref_clk,
  output sos_frame_t      req_frame,
  output logic            req_valid,
  input  wire logic       rsp_valid,
  input  wire sos_frame_t rsp_frame
);
  initial begin
    req_valid = 1'b0;
    req_frame = '0;
  end
  // One request, a bounded reply wait, then the spacing gap
  task automatic xfer(input logic [10:0] id, input logic [7:0] cmd, input logic [15:0] idx,
                      input logic [7:0] sub, input logic [31:0] w,
                      output logic got, output sos_frame_t rsp);
    got = 1'b0;
    rsp = '0;
    @(posedge ref_clk);
    #2;
    req_frame.cob_id = id;
    req_frame.dlc = SOS_FRAME_DLC;
    req_frame.data = {w, sub, idx, cmd};
    req_valid = 1'b1;
    @(posedge ref_clk);
    #2;
    req_valid = 1'b0;
    req_frame = ~req_frame; // Released lines show no stale frame
    for (int n = 0; n < 4 && !got; n++) begin
      if (rsp_valid === 1'b1) begin
        got = 1'b1;
        rsp = rsp_frame;
      end else begin
        @(posedge ref_clk);
        #2;
      end
    end
    repeat (GAP_CYC) @(posedge ref_clk);
    #2;
  endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the object server, driven through the client model.
// Assumes the package, checker and client model are compiled before it.
`timescale 1ns/1ps
module tb;
  import sos_pkg::*;
  localparam logic [6:0]  NODE = 7'h05;
  localparam logic [10:0] RX   = SOS_RX_BASE | {4'h0, NODE};
  localparam logic [15:0] HI   = 16'h1003;
  logic        ref_clk = 1'b0, rst = 1'b1, hw_fault_pin = 1'b0, can_fault_pin = 1'b0;
  logic        hist_push = 1'b0, req_valid, rsp_valid, got;
  logic [6:0]  node_id_pin = NODE;
  logic [31:0] hist_code = '0;
  logic [7:0]  err_summary;
  sos_frame_t  req_frame, rsp_frame, got_f;
  int          err_total = 0;
  int          tests_run = 0;
  always #12.5 ref_clk = ~ref_clk;
  sos_object_server #(.NAME_STR(32'h6e61_6d65), .HW_VER_STR(32'h6877_3031),
    .SW_VER_STR(32'h7377_3032)) sos_object_server_i (.ref_clk, .rst, .node_id_pin,
    .hw_fault_pin, .can_fault_pin, .hist_push, .hist_code, .req_valid, .req_frame,
    .rsp_valid, .rsp_frame, .err_summary);
  sos_master_model sos_master_model_i (.ref_clk, .req_frame, .req_valid, .rsp_valid, .rsp_frame);
  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [63:0] mk(logic [7:0] c, logic [15:0] i, logic [7:0] s, logic [31:0] w);
    return {w, s, i, c};
  endfunction
  // Request, then compare identifier, length and all eight bytes
  task automatic ask(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] w, input logic [63:0] e);
    sos_master_model_i.xfer(RX, c, i, s, w, got, got_f);
    if (got !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: no reply", $time);
      finish_test();
    end
    chk(64'({got_f.cob_id, got_f.dlc}), 64'({11'h585, 4'h8}));
    chk(got_f.data, e);
  endtask
  task automatic t_dev_type();
    ask(8'h40, 16'h1000, 8'h00, '0, mk(8'h43, 16'h1000, 8'h00, 32'h0002_0194));
    ask(8'h40, 16'h1000, 8'h01, '0, mk(8'h80, 16'h1000, 8'h01, 32'h0609_0011));
    ask(8'h23, 16'h1000, 8'h01, '1, mk(8'h80, 16'h1000, 8'h01, 32'h0609_0011));
    ask(8'h23, 16'h1000, 8'h00, '1, mk(8'h80, 16'h1000, 8'h00, 32'h0601_0002));
    ask(8'h40, 16'h1000, 8'h00, '0, mk(8'h43, 16'h1000, 8'h00, 32'h0002_0194));
  endtask
  task automatic t_order();
    logic [15:0] oth [7] = '{16'h1002, 16'h1029, 16'h1800, 16'h1803, 16'h1a00, 16'h1a03, 16'h1f80};
    ask(8'h41, 16'h2000, 8'h07, '0, mk(8'h80, 16'h2000, 8'h07, 32'h0504_0001));
    ask(8'h40, 16'h1004, 8'h07, '0, mk(8'h80, 16'h1004, 8'h07, 32'h0602_0000));
    ask(8'h2f, 16'h1804, 8'h00, '0, mk(8'h80, 16'h1804, 8'h00, 32'h0602_0000));
    ask(8'h40, 16'h2000, 8'h00, '0, mk(8'h80, 16'h2000, 8'h00, 32'h0602_0000));
    foreach (oth[k]) begin
      ask(8'h40, oth[k], 8'h00, '0, mk(8'h80, oth[k], 8'h00, 32'h0601_0000));
    end
  endtask
  task automatic t_err();
    logic [1:0] f [3] = '{2'b01, 2'b10, 2'b00};
    logic [7:0] sum;
    foreach (f[k]) begin
      {can_fault_pin, hw_fault_pin} = f[k];
      sum = {3'h0, f[k][1], 3'h0, f[k][0]};
      step(3);
      chk(64'(err_summary), 64'(sum));
      ask(8'h40, 16'h1001, 8'h00, '0, mk(8'h4f, 16'h1001, 8'h00, 32'(sum)));
    end
  endtask
  task automatic t_hist();
    logic [7:0] wc [5] = '{8'h22, 8'h23, 8'h27, 8'h2b, 8'h2f};
    for (int k = 1; k <= 11; k++) begin
      hist_push = 1'b1;
      hist_code = 32'hc0de_0000 + 32'(k);
      step(1);
    end
    hist_push = 1'b0;
    ask(8'h40, HI, 8'h00, '0, mk(8'h4f, HI, 8'h00, 32'h0a));
    ask(8'h40, HI, 8'h01, '0, mk(8'h43, HI, 8'h01, 32'hc0de_000b));
    ask(8'h40, HI, 8'h0a, '0, mk(8'h43, HI, 8'h0a, 32'hc0de_0002));
    ask(8'h40, HI, 8'h0b, '0, mk(8'h80, HI, 8'h0b, 32'h0609_0011));
    ask(8'h23, HI, 8'h01, '1, mk(8'h80, HI, 8'h01, 32'h0601_0002));
    foreach (wc[k]) ask(wc[k], HI, 8'h00, 32'hff, mk(8'h60, HI, 8'h00, '0));
    ask(8'h40, HI, 8'h00, '0, mk(8'h4f, HI, 8'h00, 32'h00));
    ask(8'h40, HI, 8'h01, '0, mk(8'h43, HI, 8'h01, 32'h00));
  endtask
  task automatic t_str();
    ask(8'h40, 16'h1008, 8'h00, '0, mk(8'h43, 16'h1008, 8'h00, 32'h6e61_6d65));
    ask(8'h40, 16'h1009, 8'h00, '0, mk(8'h43, 16'h1009, 8'h00, 32'h6877_3031));
    ask(8'h40, 16'h100a, 8'h00, '0, mk(8'h43, 16'h100a, 8'h00, 32'h7377_3032));
    ask(8'h40, 16'h100a, 8'h01, '0, mk(8'h80, 16'h100a, 8'h01, 32'h0609_0011));
    sos_master_model_i.xfer(RX + 11'h1, 8'h40, 16'h1000, 8'h00, '0, got, got_f);
    chk(64'(got), 64'h0);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #2;
    rst = 1'b0;
    step(4);
    t_dev_type();
    t_order();
    t_err();
    t_hist();
    t_str();
    finish_test();
  end
endmodule
